// ===== rtl/ssrsc_host.sv
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - Arm command writes CC to command port.
// - Disarm command writes CD to command port.
// - Store command writes 33 to command port.
// - Recall strobes low 40 to 1000 ns.
// - Command strobes low at least 30 ns.
// - Data valid 15 ns before write end.
// - Commands use output enable high, never all.
module ssrsc_host #(
   parameter int STORE_CYC  = ssrsc_pkg::STORE_WAIT_CYC,
   parameter int AUTO_CYC   = ssrsc_pkg::AUTO_WAIT_CYC
) (
   input  wire logic                       core_clk,
   input  wire logic                       rstn,
   input  wire logic                       reqValid,
   input  wire ssrsc_pkg::ssrsc_req_t      reqData,
   output var  logic                       reqReady,
   output var  logic                       rspValid,
   output var  logic [ssrsc_pkg::DATA_W-1:0] rspData,
   input  wire logic                       powerfail_detect_level,
   output var  ssrsc_pkg::ssrsc_strobe_t   strobeN,
   output var  logic [ssrsc_pkg::ADDR_W-1:0] memAddr,
   output var  logic [ssrsc_pkg::DATA_W-1:0] memDataOut,
   output var  logic                       memDataOe,
   input  wire logic [ssrsc_pkg::DATA_W-1:0] memDataIn,
   output var  logic                       powerfail_save_arm_cmd,
   output var  logic                       saveBusy
);
   import ssrsc_pkg::*;

   // ----------------------------------------------------------------
   // Types and state
   // ----------------------------------------------------------------
   typedef enum {
      S_IDLE, S_SETUP, S_PULSE, S_RECOVER, S_WAIT
   } ssrsc_state_t;

   localparam ssrsc_strobe_t STB_IDLE = '{1'b1, 1'b1, 1'b1, 1'b1};

   ssrsc_state_t        state_reg;
   ssrsc_req_t          cur_reg;
   logic [CNT_W-1:0]    cnt_reg;
   logic [2:0]          pfSync_reg;
   logic                pfLevel_reg;

   // ----------------------------------------------------------------
   // Helper functions
   // ----------------------------------------------------------------
   function automatic logic isCmd(input ssrsc_op_t op);
      return (op == SSRSC_OP_ARM) || (op == SSRSC_OP_DISARM) || (op == SSRSC_OP_STORE);
   endfunction : isCmd

   function automatic logic [CNT_W-1:0] cyc(input int n);
      return CNT_W'(n - 1);
   endfunction : cyc

   // Byte put on the data pins: a fixed code for commands, else the write data.
   function automatic logic [DATA_W-1:0] outByte(input ssrsc_req_t r);
      logic [DATA_W-1:0] b;
      if (r.op == SSRSC_OP_ARM) begin
         b = CMD_ARM;
      end else if (r.op == SSRSC_OP_DISARM) begin
         b = CMD_DISARM;
      end else if (r.op == SSRSC_OP_STORE) begin
         b = CMD_STORE;
      end else begin
         b = r.data;
      end
      return b;
   endfunction : outByte

   // Strobes held low during the pulse; all four low at once never occurs.
   function automatic ssrsc_strobe_t stbFor(input ssrsc_op_t op);
      ssrsc_strobe_t s;
      case (op)
         SSRSC_OP_READ:   s = '{1'b0, 1'b1, 1'b0, 1'b1};
         SSRSC_OP_WRITE:  s = '{1'b0, 1'b0, 1'b1, 1'b1};
         SSRSC_OP_RECALL: s = '{1'b0, 1'b1, 1'b0, 1'b0};
         default:         s = '{1'b0, 1'b0, 1'b1, 1'b0};
      endcase
      return s;
   endfunction : stbFor

   // ----------------------------------------------------------------
   // Power-fail detect synchroniser
   // ----------------------------------------------------------------
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         pfSync_reg  <= 3'h0;
         pfLevel_reg <= 1'b0;
      end else begin
         pfSync_reg <= {pfSync_reg[1:0], powerfail_detect_level};
         if (pfSync_reg[1] == pfSync_reg[2]) begin
            pfLevel_reg <= pfSync_reg[2];
         end
      end
   end

   // ----------------------------------------------------------------
   // Sequencer
   // ----------------------------------------------------------------
   // A high detect level while armed means the device is saving itself;
   // the host then holds everything off for the whole save.
   logic pfStart;
   assign pfStart = pfLevel_reg && powerfail_save_arm_cmd;

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         state_reg  <= S_IDLE;
         cur_reg    <= '0;
         cnt_reg    <= '0;
         strobeN    <= STB_IDLE;
         memAddr    <= '0;
         memDataOut <= '0;
         memDataOe  <= 1'b0;
         reqReady   <= 1'b0;
         rspValid   <= 1'b0;
         rspData    <= '0;
         saveBusy   <= 1'b0;
      end else begin
         rspValid <= 1'b0;
         case (state_reg)
            S_IDLE: begin
               strobeN   <= STB_IDLE;
               memDataOe <= 1'b0;
               if (pfStart) begin
                  reqReady  <= 1'b0;
                  saveBusy  <= 1'b1;
                  cnt_reg   <= cyc(AUTO_CYC);
                  state_reg <= S_WAIT;
               end else if (reqValid && reqReady) begin
                  reqReady   <= 1'b0;
                  cur_reg    <= reqData;
                  memAddr    <= reqData.addr;
                  memDataOe  <= (reqData.op != SSRSC_OP_READ) && (reqData.op != SSRSC_OP_RECALL);
                  memDataOut <= outByte(reqData);
                  cnt_reg    <= cyc(SETUP_CYC);
                  state_reg  <= S_SETUP;
               end else begin
                  reqReady <= 1'b1;
               end
            end
            S_SETUP: begin
               // Data and address settle before any strobe falls.
               if (cnt_reg == '0) begin
                  cnt_reg   <= cyc(STROBE_CYC);
                  state_reg <= S_PULSE;
                  strobeN   <= stbFor(cur_reg.op);
               end else begin
                  cnt_reg <= cnt_reg - CNT_W'(1);
               end
            end
            S_PULSE: begin
               // The pulse is a fixed 40 ns, the shortest length the recall window allows.
               if (cnt_reg == '0) begin
                  strobeN   <= STB_IDLE;
                  rspData   <= memDataIn;
                  cnt_reg   <= cyc(RECOVERY_CYC);
                  state_reg <= S_RECOVER;
               end else begin
                  cnt_reg <= cnt_reg - CNT_W'(1);
               end
            end
            S_RECOVER: begin
               // Data stays driven through recovery to give hold time.
               if (cnt_reg == '0) begin
                  memDataOe <= 1'b0;
                  if (cur_reg.op == SSRSC_OP_RECALL) begin
                     cnt_reg   <= cyc(RECALL_WAIT_CYC);
                     state_reg <= S_WAIT;
                  end else if (cur_reg.op == SSRSC_OP_STORE) begin
                     saveBusy  <= 1'b1;
                     cnt_reg   <= cyc(STORE_CYC);
                     state_reg <= S_WAIT;
                  end else begin
                     rspValid  <= 1'b1;
                     state_reg <= S_IDLE;
                  end
               end else begin
                  cnt_reg <= cnt_reg - CNT_W'(1);
               end
            end
            S_WAIT: begin
               if (cnt_reg == '0) begin
                  saveBusy  <= 1'b0;
                  rspValid  <= 1'b1;
                  state_reg <= S_IDLE;
               end else begin
                  cnt_reg <= cnt_reg - CNT_W'(1);
               end
            end
            default: state_reg <= S_IDLE;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Mirror of the device arming latch
   // ----------------------------------------------------------------
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         powerfail_save_arm_cmd <= 1'b0;
      end else if (state_reg == S_WAIT && saveBusy && pfStart) begin
         powerfail_save_arm_cmd <= 1'b1;
      end else if (state_reg == S_RECOVER && cnt_reg == '0 && isCmd(cur_reg.op)) begin
         if (cur_reg.op == SSRSC_OP_ARM) begin
            powerfail_save_arm_cmd <= 1'b1;
         end else if (cur_reg.op == SSRSC_OP_DISARM) begin
            powerfail_save_arm_cmd <= 1'b0;
         end
      end
   end
endmodule : ssrsc_host
`default_nettype wire

// ===== rtl/ssrsc_pkg.sv
package ssrsc_pkg;
   // ----------------------------------------------------------------
   // Clock and timing
   // ----------------------------------------------------------------
   localparam int CLK_PERIOD_NS   = 10;
   localparam int STROBE_NS       = 40;
   localparam int RECALL_MAX_NS   = 1000;
   localparam int DATA_SETUP_NS   = 15;
   localparam int RECOVERY_NS     = 35;
   localparam int RECALL_US       = 10;
   localparam int STORE_MS        = 5;
   localparam int AUTO_MS         = 3;
   localparam int STROBE_CYC      = (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int RECALL_MAX_CYC  = RECALL_MAX_NS / CLK_PERIOD_NS;
   localparam int SETUP_CYC       = (DATA_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int RECOVERY_CYC    = (RECOVERY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int RECALL_WAIT_CYC = RECALL_US * 1000 / CLK_PERIOD_NS;
   localparam int STORE_WAIT_CYC  = STORE_MS * 1000000 / CLK_PERIOD_NS;
   localparam int AUTO_WAIT_CYC   = AUTO_MS * 1000000 / CLK_PERIOD_NS;
   localparam int CNT_W           = 24;

   // ----------------------------------------------------------------
   // Command data values and widths
   // ----------------------------------------------------------------
   localparam logic [7:0] CMD_ARM    = 8'hCC;
   localparam logic [7:0] CMD_DISARM = 8'hCD;
   localparam logic [7:0] CMD_STORE  = 8'h33;
   localparam int ADDR_W = 11;
   localparam int DATA_W = 8;

   // ----------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      SSRSC_OP_READ, SSRSC_OP_WRITE, SSRSC_OP_RECALL,
      SSRSC_OP_ARM, SSRSC_OP_DISARM, SSRSC_OP_STORE
   } ssrsc_op_t;

   typedef struct packed {
      ssrsc_op_t          op;
      logic [ADDR_W-1:0]  addr;
      logic [DATA_W-1:0]  data;
   } ssrsc_req_t;

   typedef struct packed {
      logic chipEnableN;
      logic writeEnableN;
      logic outputEnableN;
      logic nonvolatileSelectN;
   } ssrsc_strobe_t;
endpackage : ssrsc_pkg

// ===== tb/ssrsc_checker.sv
`timescale 1ns/1ps
`default_nettype none
module ssrsc_checker (
   input wire logic                         core_clk,
   input wire logic                         rstn,
   input wire logic                         rspValid,
   input wire ssrsc_pkg::ssrsc_strobe_t     strobeN,
   input wire logic [ssrsc_pkg::DATA_W-1:0] memDataOut,
   input wire logic                         memDataOe,
   input wire logic                         saveBusy
);
   import ssrsc_pkg::*;
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rstn);
   wire wr   = !strobeN.chipEnableN && !strobeN.writeEnableN;
   wire cmd  = wr && !strobeN.nonvolatileSelectN;
   wire wram = wr && strobeN.nonvolatileSelectN;
   wire rcl  = !strobeN.chipEnableN && !strobeN.outputEnableN && !strobeN.nonvolatileSelectN;
   sequence s_cmd; cmd [*4] ##1 !cmd; endsequence
   sequence s_rcl; rcl [*4] ##1 !rcl; endsequence
   a_cmd_pulse: assert property ($rose(cmd) |-> s_cmd) else $error("bad pulse");
   a_recall_pulse: assert property ($rose(rcl) |-> s_rcl) else $error("bad recall");
   a_cmd_oe: assert property (cmd |-> strobeN.outputEnableN) else $error("oe low");
   a_wr_data: assert property (wr |-> memDataOe && $stable(memDataOut)) else $error("no data");
   a_wr_answer: assert property ($fell(wram) |-> ##4 rspValid) else $error("no answer");
   a_store_busy: assert property ($fell(cmd) && $past(memDataOut) == CMD_STORE
      |-> ##[0:6] saveBusy) else $error("store not busy");
   a_host_float: assert property (!strobeN.outputEnableN |-> !memDataOe) else $error("clash");
   a_busy_quiet: assert property (saveBusy |-> strobeN.chipEnableN) else $error("busy op");
endmodule : ssrsc_checker
bind ssrsc_host ssrsc_checker i_ssrsc_checker (.core_clk, .rstn, .rspValid, .strobeN,
   .memDataOut, .memDataOe, .saveBusy);
`default_nettype wire

// ===== tb/ssrsc_dev_model.sv
`timescale 1ns/1ps
`default_nettype none
module ssrsc_dev_model (
   input wire logic                         core_clk,
   input wire ssrsc_pkg::ssrsc_strobe_t     strobeN,
   input wire logic [ssrsc_pkg::ADDR_W-1:0] memAddr,
   input wire logic [ssrsc_pkg::DATA_W-1:0] memDataOut,
   input wire logic                         pfail,
   output var logic [ssrsc_pkg::DATA_W-1:0] memDataIn,
   output var logic                         armed = 1'b0
);
   import ssrsc_pkg::*;
   logic [DATA_W-1:0] ram [2**ADDR_W], shadow [2**ADDR_W], lastOut = 8'h00;
   logic              busy = 1'b0;
   ssrsc_strobe_t     p = '1;
   // A released bus shows the inverse of the last byte, so stale data never reads as good.
   assign memDataIn = (!strobeN.chipEnableN && !strobeN.outputEnableN && strobeN.writeEnableN
      && strobeN.nonvolatileSelectN && !busy) ? ram[memAddr] : ~lastOut;
   always @(posedge core_clk) begin
      lastOut = memDataIn;
      if (armed && pfail && !busy) shadow = ram;
      busy = busy || (armed && pfail);
      if (!busy && !p.chipEnableN && !p.writeEnableN && strobeN.writeEnableN) begin
         if (p.nonvolatileSelectN) ram[memAddr] = memDataOut;
         else if (memDataOut == CMD_ARM) armed = 1'b1;
         else if (memDataOut == CMD_DISARM) armed = 1'b0;
         else if (memDataOut == CMD_STORE) shadow = ram;
      end
      if (!busy && !p.outputEnableN && !p.nonvolatileSelectN && strobeN.nonvolatileSelectN)
         ram = shadow;
      p = strobeN;
   end
endmodule : ssrsc_dev_model
`default_nettype wire

// ===== tb/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
   import ssrsc_pkg::*;
   logic              core_clk = 1'b0, rstn = 1'b0, reqValid = 1'b0, pfail = 1'b0;
   logic              reqReady, rspValid, memDataOe, armCmd, saveBusy, armed;
   ssrsc_req_t        reqData = '0;
   ssrsc_strobe_t     strobeN;
   logic [DATA_W-1:0] rspData, memDataOut, memDataIn, d [8];
   logic [ADDR_W-1:0] memAddr, a [8];
   int                fail_count = 0, total_checks = 0, seed = 74, lat, n;
   localparam int     SAVE_CYC = 20;
   ssrsc_host #(.STORE_CYC(SAVE_CYC), .AUTO_CYC(SAVE_CYC)) i_ssrsc_host (.core_clk, .rstn, .reqValid,
      .reqData, .reqReady, .rspValid, .rspData, .powerfail_detect_level(pfail), .strobeN,
      .memAddr, .memDataOut, .memDataOe, .memDataIn, .powerfail_save_arm_cmd(armCmd), .saveBusy);
   ssrsc_dev_model i_ssrsc_dev_model (.core_clk, .strobeN, .memAddr, .memDataOut, .pfail,
      .memDataIn, .armed);
   initial forever #5 core_clk = ~core_clk;
   // The latency count reads one on the first falling edge after the take.
   function automatic int expLat(ssrsc_op_t o);
      int base;
      base = SETUP_CYC + STROBE_CYC + RECOVERY_CYC + 1;
      if (o == SSRSC_OP_RECALL) return base + RECALL_WAIT_CYC;
      if (o == SSRSC_OP_STORE) return base + SAVE_CYC;
      return base;
   endfunction : expLat
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) fail_count++;
      if (seen !== exp) $display("wrong value at %0t seen %0h expected %0h", $time, seen, exp);
   endtask : check
   task automatic results();
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : results
   task automatic op(input ssrsc_op_t o, input logic [ADDR_W-1:0] ad, input logic [7:0] dt);
      reqData = '{o, ad, dt};
      reqValid = 1'b1;
      for (n = 0; n < 99 && reqReady !== 1'b1; n++) @(negedge core_clk);
      @(negedge core_clk);
      reqValid = 1'b0;
      for (lat = 1; lat < 2000 && rspValid !== 1'b1; lat++) @(negedge core_clk);
      check(lat, expLat(o));
      if (n == 99 || lat == 2000) begin
         fail_count++;
         results();
      end
   endtask : op
   task automatic rd(input int i);
      op(SSRSC_OP_READ, a[i], 8'h00);
      check(rspData, d[i]);
   endtask : rd
   initial begin
      repeat (4) @(negedge core_clk);
      rstn = 1'b1;
      repeat (2) @(negedge core_clk);
      for (int i = 0; i < 8; i++) begin
         a[i] = {i[2:0], (i == 0) ? 8'h00 : (i == 7) ? 8'hFF : 8'($random(seed))};
         d[i] = 8'($random(seed));
         op(SSRSC_OP_WRITE, a[i], d[i]);
      end
      for (int i = 7; i >= 0; i--) rd(i);
      $display("write and read test done");
      op(SSRSC_OP_STORE, 11'h000, 8'h00);
      for (int i = 0; i < 8; i++) op(SSRSC_OP_WRITE, a[i], ~d[i]);
      op(SSRSC_OP_RECALL, 11'h000, 8'h00);
      for (int i = 0; i < 8; i++) rd(i);
      $display("store and recall test done");
      op(SSRSC_OP_ARM, 11'h000, 8'h00);
      check({armCmd, armed}, 2'b11);
      op(SSRSC_OP_DISARM, 11'h000, 8'h00);
      check({armCmd, armed}, 2'b00);
      op(SSRSC_OP_ARM, 11'h000, 8'h00);
      op(SSRSC_OP_WRITE, a[0], 8'h5A);
      pfail = 1'b1;
      repeat (10) @(negedge core_clk);
      reqValid = 1'b1;
      repeat (4) @(negedge core_clk);
      check(saveBusy, 1'b1);
      check(armCmd, 1'b1);
      check(reqReady, 1'b0);
      check(i_ssrsc_dev_model.shadow[a[0]], 8'h5A);
      check(strobeN.chipEnableN, 1'b1);
      $display("power fail test done");
      results();
   end
endmodule : tb
`default_nettype wire
